/* File: fws_pkg.sv */
/*
 * shared constants, types and register map of the flash status and
 * protection controller.
 * assumes a 100 MHz mclk and an 8-bit flash data path.
 */
package fws_pkg;

    // ==========================================================
    // widths and clock
    localparam int ADDR_W  = 20;
    localparam int DQ_W    = 8;
    localparam int CLK_NS  = 10;
    localparam int SYNC_LAT = 4;

    // ==========================================================
    // pin timing, least times rounded up to whole cycles; the read count adds SYNC_LAT on top
    localparam int T_WP_NS  = 35;
    localparam int T_WPH_NS = 30;
    localparam int T_ACC_NS = 90;
    localparam logic [15:0] WP_CYC  = 16'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WPH_CYC = 16'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RD_CYC  =
        16'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_RES  = 8'h10;
    localparam logic [7:0] REG_CFG  = 8'h14;

    // ==========================================================
    // status bit positions
    localparam int ST_BUSY     = 0;
    localparam int ST_DONE     = 1;
    localparam int ST_TIMEOUT  = 2;
    localparam int ST_FAIL     = 3;
    localparam int ST_REJECT   = 4;
    localparam int ST_NEED_RST = 5;
    localparam int ST_REFUSED  = 6;
    localparam int ST_READY    = 7;
    localparam int ST_PROT     = 8;

    // ==========================================================
    // data bit positions of the flash status and verify words, and address bit positions
    localparam int DQ_POLL   = 7;
    localparam int DQ_TOG1   = 6;
    localparam int DQ_TIMEOUT = 5;
    localparam int DQ_WINDOW = 3;
    localparam int DQ_ZERO   = 0;
    localparam int A_ZERO    = 0;
    localparam int A_ONE     = 1;
    localparam int A_SIX     = 6;

    typedef enum logic [2:0] {
        OP_WRITE, OP_READ, OP_POLL, OP_ERASE_ADD,
        OP_PROTECT, OP_UNPROTECT, OP_VERIFY
    } fws_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   dq_o;
        logic              dq_oe;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              a9_hv;
        logic              oe_hv;
        logic              rst_hv;
    } fws_pins_t;

    localparam fws_pins_t PINS_IDLE = '{
        addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, a9_hv: 1'b0, oe_hv: 1'b0, rst_hv: 1'b0};

endpackage

/* File: fws_sync.sv */
/*
 * three-stage input synchroniser; a bit changes only once stages two
 * and three agree.
 * assumes inputs come from pins outside the mclk domain.
 */
`timescale 1ns/1ps
module fws_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] q;
    } fws_sync_t;

    fws_sync_t s_reg;
    fws_sync_t s_next;

    // ==========================================================
    // stages
    always_comb begin
        s_next    = s_reg;
        s_next.f1 = din;
        s_next.f2 = s_reg.f1;
        s_next.f3 = s_reg.f2;
        // first stage read by the second stage only
        s_next.q  = (~(s_reg.f2 ^ s_reg.f3) & s_reg.f2)
                  | ((s_reg.f2 ^ s_reg.f3) & s_reg.q);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.q;
endmodule

/* File: fws_host.sv */
/*
 * host controller that drives a parallel nor flash through its pins:
 * write and read cycles, status polling, erase window checks, sector
 * protect, chip unprotect, protect verify and temporary unprotect.
 * assumes level translation turns a9_hv, oe_hv and rst_hv into the
 * high_voltage_level on the pins, and a pull-up on ready_busy.
 */
// Added by the designer: the register offsets and strobed register access.
// Operation
// - reset command before further program or erase
// - poll with a valid relevant address
// - check window flag before and after
// - write only with chip select, strobe low, oe high
// - reset pin high voltage: temporary unprotect
// - protect: high voltage a9, oe, strobe pulse
// - unprotect: a9 oe high voltage, a6 high
// - protect all sectors before chip unprotect (code only needs one protect pulse since the last unprotect)
`timescale 1ns/1ps
module fws_host #(
    parameter logic [15:0]          PROT_CYC   = 16'h03E8,
    parameter logic [15:0]          POLL_LIMIT = 16'h0FA0,
    parameter logic [fws_pkg::DQ_W-1:0] RESET_CMD = 8'hF0
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic                      clk_en,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    output fws_pkg::fws_pins_t             pins,
    input  wire logic [fws_pkg::DQ_W-1:0]  dq_i,
    input  wire logic                      ready_busy_output
);
    typedef enum logic [1:0] {S_IDLE, S_ACT, S_REC, S_DECIDE} fws_st_t;

    typedef struct packed {
        fws_st_t                    st;
        fws_pkg::fws_op_t           op;
        logic [1:0]                 step;
        logic [15:0]                cnt;
        logic [15:0]                loops;
        logic                       is_rd;
        logic                       armed;
        fws_pkg::fws_pins_t         pins;
        logic [fws_pkg::ADDR_W-1:0] addr;
        logic [fws_pkg::DQ_W-1:0]   data;
        logic [fws_pkg::DQ_W-1:0]   first;
        logic [fws_pkg::DQ_W-1:0]   last;
        logic [8:0]                 stat;
        logic [31:0]                rdata;
    } fws_state_t;

    fws_state_t r_reg;
    fws_state_t r_next;
    logic [fws_pkg::DQ_W-1:0] dq_s;
    logic                     rb_s;

    // ==========================================================
    // pin inputs
    fws_sync #(.W(fws_pkg::DQ_W + 1)) u_sync (
        .mclk   (mclk),
        .reset  (reset),
        .clk_en (clk_en),
        .din    ({ready_busy_output, dq_i}),
        .dout   ({rb_s, dq_s})
    );

    // ==========================================================
    // bus cycle launch
    function automatic fws_state_t launch(fws_state_t s, logic rd,
                                          logic [15:0] len);
        s.st          = S_ACT;
        s.is_rd       = rd;
        s.cnt         = len;
        s.pins.ce_n   = 1'b0;
        s.pins.we_n   = rd;
        // oe pin stays logic high on writes, so no write with oe low
        s.pins.oe_n   = ~rd;
        s.pins.dq_oe  = ~rd;
        return s;
    endfunction

    function automatic fws_state_t finish(fws_state_t s);
        s.st         = S_IDLE;
        s.pins.a9_hv = 1'b0;
        s.pins.oe_hv = 1'b0;
        s.stat[fws_pkg::ST_BUSY] = 1'b0;
        s.stat[fws_pkg::ST_DONE] = 1'b1;
        return s;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic ok;
        logic tog;
        r_next = r_reg;
        ok     = 1'b0;
        tog    = r_reg.last[fws_pkg::DQ_TOG1] != r_reg.first[fws_pkg::DQ_TOG1];
        r_next.stat[fws_pkg::ST_READY] = rb_s;

        // software side: done, refused and reject stat flags clear by writing ones
        if (reg_wr && reg_addr == fws_pkg::REG_ADDR) begin
            r_next.addr = reg_wdata[fws_pkg::ADDR_W-1:0];
        end else if (reg_wr && reg_addr == fws_pkg::REG_DATA) begin
            r_next.data = reg_wdata[fws_pkg::DQ_W-1:0];
        end else if (reg_wr && reg_addr == fws_pkg::REG_STAT) begin
            r_next.stat[fws_pkg::ST_DONE]    = r_reg.stat[fws_pkg::ST_DONE]
                & ~reg_wdata[fws_pkg::ST_DONE];
            r_next.stat[fws_pkg::ST_REFUSED] = r_reg.stat[fws_pkg::ST_REFUSED]
                & ~reg_wdata[fws_pkg::ST_REFUSED];
            r_next.stat[fws_pkg::ST_REJECT]  = r_reg.stat[fws_pkg::ST_REJECT]
                & ~reg_wdata[fws_pkg::ST_REJECT];
        end else if (reg_wr && reg_addr == fws_pkg::REG_CFG) begin
            // dropping the level gives protection back to the device
            r_next.pins.rst_hv = reg_wdata[0];
        end

        if (reg_rd && reg_addr == fws_pkg::REG_STAT) begin
            r_next.rdata = {23'h00_0000, r_reg.stat};
        end else if (reg_rd && reg_addr == fws_pkg::REG_RES) begin
            r_next.rdata = {16'h0000, r_reg.first, r_reg.last};
        end else if (reg_rd && reg_addr == fws_pkg::REG_ADDR) begin
            r_next.rdata = 32'(r_reg.addr);
        end else if (reg_rd && reg_addr == fws_pkg::REG_DATA) begin
            r_next.rdata = 32'(r_reg.data);
        end else if (reg_rd && reg_addr == fws_pkg::REG_CFG) begin
            r_next.rdata = {31'h0000_0000, r_reg.pins.rst_hv};
        end else if (reg_rd) begin
            r_next.rdata = 32'h0000_0000;
        end

        case (r_reg.st)
        S_IDLE: begin
            if (reg_wr && reg_addr == fws_pkg::REG_CMD) begin
                r_next.op   = fws_pkg::fws_op_t'(reg_wdata[2:0]);
                r_next.step = 2'd0;
                r_next.loops = 16'h0000;
                // after a timeout only polling or the reset command
                ok = !r_reg.stat[fws_pkg::ST_NEED_RST]
                   || r_next.op == fws_pkg::OP_POLL
                   || (r_next.op == fws_pkg::OP_WRITE
                       && r_reg.data == RESET_CMD);
                if (r_next.op > fws_pkg::OP_VERIFY) begin
                    ok = 1'b0;
                end
                // chip unprotect only after a protect pulse
                if (r_next.op == fws_pkg::OP_UNPROTECT && !r_reg.armed) begin
                    ok = 1'b0;
                end
                if (!ok) begin
                    r_next.stat[fws_pkg::ST_REFUSED] = 1'b1;
                end else begin
                    r_next.stat[fws_pkg::ST_BUSY] = 1'b1;
                    r_next.pins.addr = r_reg.addr;
                    r_next.pins.dq_o = r_reg.data;
                    case (r_next.op)
                    fws_pkg::OP_WRITE: begin
                        r_next = launch(r_next, 1'b0, fws_pkg::WP_CYC);
                        if (r_reg.data == RESET_CMD) begin
                            r_next.stat[fws_pkg::ST_NEED_RST] = 1'b0;
                            r_next.stat[fws_pkg::ST_TIMEOUT]  = 1'b0;
                        end
                    end
                    fws_pkg::OP_PROTECT: begin
                        r_next.pins.a9_hv = 1'b1;
                        r_next.pins.oe_hv = 1'b1;
                        r_next.armed      = 1'b1;
                        r_next = launch(r_next, 1'b0, PROT_CYC);
                    end
                    fws_pkg::OP_UNPROTECT: begin
                        r_next.pins.a9_hv = 1'b1;
                        r_next.pins.oe_hv = 1'b1;
                        r_next.armed      = 1'b0;
                        r_next.pins.addr[fws_pkg::A_SIX] = 1'b1;
                        r_next = launch(r_next, 1'b0, PROT_CYC);
                    end
                    fws_pkg::OP_VERIFY: begin
                        r_next.pins.a9_hv = 1'b1;
                        r_next.pins.addr[fws_pkg::A_ONE]  = 1'b1;
                        r_next.pins.addr[fws_pkg::A_ZERO] = 1'b0;
                        r_next.pins.addr[fws_pkg::A_SIX]  = 1'b0;
                        r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                    end
                    default: begin
                        r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                    end
                    endcase
                end
            end
        end
        S_ACT: begin
            if (r_reg.cnt <= 16'h0001) begin
                if (r_reg.is_rd) begin
                    r_next.first = r_reg.last;
                    r_next.last  = dq_s;
                end
                r_next.pins.ce_n  = 1'b1;
                r_next.pins.oe_n  = 1'b1;
                r_next.pins.we_n  = 1'b1;
                r_next.pins.dq_oe = 1'b0;
                r_next.st  = S_REC;
                r_next.cnt = fws_pkg::WPH_CYC;
            end else begin
                r_next.cnt = r_reg.cnt - 16'h0001;
            end
        end
        S_REC: begin
            if (r_reg.cnt <= 16'h0001) begin
                r_next.st = S_DECIDE;
            end else begin
                r_next.cnt = r_reg.cnt - 16'h0001;
            end
        end
        S_DECIDE: begin
            case (r_reg.op)
            fws_pkg::OP_POLL: begin
                // two reads before any compare of toggle_bit_one
                if (r_reg.step == 2'd0) begin
                    r_next.step = 2'd1;
                    r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                end else if (!tog) begin
                    r_next = finish(r_next);
                end else if (r_reg.step == 2'd2) begin
                    // still toggling after timeout_flag: failed run
                    r_next.stat[fws_pkg::ST_TIMEOUT]  = 1'b1;
                    r_next.stat[fws_pkg::ST_FAIL]     = 1'b1;
                    r_next.stat[fws_pkg::ST_NEED_RST] = 1'b1;
                    r_next = finish(r_next);
                end else if (r_reg.last[fws_pkg::DQ_TIMEOUT]) begin
                    r_next.step = 2'd2;
                    r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                end else if (r_reg.loops >= POLL_LIMIT) begin
                    r_next.stat[fws_pkg::ST_FAIL] = 1'b1;
                    r_next = finish(r_next);
                end else begin
                    r_next.loops = r_reg.loops + 16'h0001;
                    r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                end
            end
            fws_pkg::OP_ERASE_ADD: begin
                if (r_reg.step == 2'd0) begin
                    // window closed: the device would drop the command
                    if (r_reg.last[fws_pkg::DQ_WINDOW]) begin
                        r_next.stat[fws_pkg::ST_REJECT] = 1'b1;
                        r_next = finish(r_next);
                    end else begin
                        r_next.step = 2'd1;
                        r_next = launch(r_next, 1'b0, fws_pkg::WP_CYC);
                    end
                end else if (r_reg.step == 2'd1) begin
                    r_next.step = 2'd2;
                    r_next = launch(r_next, 1'b1, fws_pkg::RD_CYC);
                end else begin
                    if (r_reg.last[fws_pkg::DQ_WINDOW]) begin
                        r_next.stat[fws_pkg::ST_REJECT] = 1'b1;
                    end
                    r_next = finish(r_next);
                end
            end
            fws_pkg::OP_VERIFY: begin
                r_next.stat[fws_pkg::ST_PROT] =
                    r_reg.last[fws_pkg::DQ_ZERO];
                r_next = finish(r_next);
            end
            default: begin
                r_next = finish(r_next);
            end
            endcase
        end
        default: begin
            r_next.st = S_IDLE;
        end
        endcase
    end

    // ==========================================================
    // registers; reset leaves every strobe high
    always_ff @(posedge mclk) begin
        if (reset) begin
            r_reg       <= '0;
            r_reg.st    <= S_IDLE;
            r_reg.pins  <= fws_pkg::PINS_IDLE;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    assign pins      = r_reg.pins;
    assign reg_rdata = r_reg.rdata;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    wr_inhibit_a: assert property (
        !pins.we_n |-> pins.oe_n && !pins.ce_n)
        else $error("write strobe low with oe low or chip deselected");
    strobe_width_a: assert property (
        $fell(pins.we_n) |-> !pins.we_n [*4])
        else $error("write strobe pulse shorter than four cycles");
    prot_hv_a: assert property (
        !pins.we_n && pins.a9_hv |-> pins.oe_hv)
        else $error("high voltage write without oe high voltage");
    unprot_a6_a: assert property (
        !pins.we_n && r_reg.op == fws_pkg::OP_UNPROTECT
        |-> pins.addr[fws_pkg::A_SIX] && !pins.ce_n)
        else $error("unprotect pulse without a6 high");
    verify_addr_a: assert property (
        pins.a9_hv && !pins.oe_n |-> pins.addr[fws_pkg::A_ONE]
        && !pins.addr[fws_pkg::A_ZERO] && !pins.addr[fws_pkg::A_SIX])
        else $error("verify read with wrong address bits");
    temp_unprot_a: assert property (
        clk_en && reg_wr && reg_addr == fws_pkg::REG_CFG
        |=> pins.rst_hv == $past(reg_wdata[0]))
        else $error("reset pin level does not follow config");
    need_reset_a: assert property (
        r_reg.stat[fws_pkg::ST_NEED_RST] && !pins.we_n
        |-> pins.dq_o == RESET_CMD)
        else $error("write other than reset after timeout");
    power_up_a: assert property (
        $past(reset) |-> pins.we_n && pins.ce_n && pins.oe_n)
        else $error("strobes not idle after reset");
    reject_a: assert property (
        r_reg.st == S_DECIDE && r_reg.op == fws_pkg::OP_ERASE_ADD
        && r_reg.step == 2'd0 && r_reg.last[fws_pkg::DQ_WINDOW] && clk_en
        |=> r_reg.st == S_IDLE && r_reg.stat[fws_pkg::ST_REJECT])
        else $error("erase command sent with window closed");

    poll_done_c: cover property (
        r_reg.op == fws_pkg::OP_POLL && $fell(r_reg.stat[fws_pkg::ST_BUSY]));
    timeout_c: cover property ($rose(r_reg.stat[fws_pkg::ST_TIMEOUT]));
    protect_c: cover property (
        r_reg.op == fws_pkg::OP_PROTECT && $rose(pins.we_n));
    reject_c: cover property ($rose(r_reg.stat[fws_pkg::ST_REJECT]));
endmodule

/* File: fws_flash_model.sv */
/* behavioural flash with one sector for the fws_host bench.
   assumes pins come straight from fws_host, ready line pulled up. */
`timescale 1ns/1ps
module fws_flash_model #(
    parameter int BUSY_READS = 3
) (
    input  fws_pkg::fws_pins_t pins,
    input  wire logic          fail_mode,
    input  wire logic          window_closed,
    input  wire logic          suspend,
    output logic [7:0]         dq_i,
    output logic               ready_busy_output
);
    // ==========================================================
    // state, read mode from power-up
    int                 busy_reads = 0;
    logic               tog = 1'b0, prot = 1'b0, timed_out = 1'b0;
    logic [7:0]         array_q = 8'h00, last_q = 8'h00, val;
    realtime            fall_t = 0.0;
    fws_pkg::fws_pins_t prev = fws_pkg::PINS_IDLE;
    wire                drv = !pins.ce_n && !pins.oe_n;
    wire                busy = busy_reads > 0 || timed_out;
    logic               wr_end;
    // ==========================================================
    // read data
    always_comb begin
        if (pins.a9_hv)
            val = {7'h00, prot & pins.addr[1] & !pins.addr[0]
                   & !pins.addr[6]};
        else if (suspend)
            val = {5'h10, tog, 2'h0};
        else if (busy)
            val = {~array_q[7], tog, timed_out, 1'b0, window_closed, 3'h0};
        else
            val = array_q;
    end
    // released bus shows the inverse, never a stale byte
    always @*
        if (drv) last_q = val;
    assign dq_i = drv ? val : ~last_q;
    assign ready_busy_output = !busy || suspend;
    // ==========================================================
    // pin events; rst_hv never touches prot, so it returns
    always @(pins) begin
        // worked out here: a net would race this event
        wr_end = !prev.we_n && pins.we_n && !prev.ce_n;
        if (prev.we_n && !pins.we_n)
            fall_t = $realtime;
        if (!prev.ce_n && !prev.oe_n && (pins.ce_n || pins.oe_n)
            && (busy || suspend)) begin
            tog = ~tog;
            if (busy_reads > 0)
                busy_reads--;
        end
        // glitches under 5 ns start nothing
        if (wr_end && $realtime - fall_t >= 5.0) begin
            if (prev.a9_hv && prev.oe_hv)
                prot = !prev.addr[6];
            else if (prev.oe_n && prev.dq_o == 8'hF0)
                timed_out = 1'b0;
            else if (prev.oe_n && !timed_out && !(busy && window_closed)) begin
                array_q = prev.dq_o;
                busy_reads = BUSY_READS;
                timed_out = fail_mode;
            end
        end
        prev = pins;
    end
endmodule

/* File: fws_host_tb.sv */
/* self-checking bench for fws_host driving the flash model.
   assumes the fws_pkg register map and status bit layout. */
`timescale 1ns/1ps
module fws_host_tb;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
    } fws_note_t;
    logic               mclk = 1'b0, reset = 1'b1, rd_late_reg = 1'b0;
    logic               reg_wr = 1'b0, reg_rd = 1'b0, ready_busy_output;
    logic               fail_mode = 1'b0, window_closed = 1'b0;
    logic               suspend = 1'b0, clk_en = 1'b1;
    logic [7:0]         reg_addr = 8'h00, dq_i;
    logic [31:0]        reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic [31:0]        seed = 32'h0000_5713;
    fws_pkg::fws_pins_t pins;
    fws_note_t          note, notes[$];
    int                 fails = 0, tests_run = 0;

    always #5 mclk = ~mclk;
    // short counts keep protect pulses and poll loops brief
    fws_host #(.PROT_CYC(16'h0008), .POLL_LIMIT(16'h0008)) fws_host_i (
        .mclk(mclk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pins(pins), .dq_i(dq_i),
        .ready_busy_output(ready_busy_output));
    fws_flash_model fws_flash_model_i (
        .pins(pins), .fail_mode(fail_mode), .window_closed(window_closed),
        .suspend(suspend),
        .dq_i(dq_i), .ready_busy_output(ready_busy_output));
    // ==========================================================
    // read data land the cycle after the strobe
    always @(posedge mclk) begin
        rd_late_reg <= reg_rd;
        if (rd_late_reg) begin
            note = notes.pop_front();
            if (note.mask != 32'h0000_0000) begin
                tests_run++;
                if ((reg_rdata & note.mask) !== note.exp) begin
                    fails++;
                    $display("MISMATCH t=%0t read %h want %h", $time,
                             reg_rdata & note.mask, note.exp);
                end
            end
        end
    end
    // ==========================================================
    // bus tasks; a free cycle after each strobe avoids double drives
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        notes.push_back('{e & m, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400; i++) begin
            rd(fws_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0000);
            if (reg_rdata[fws_pkg::ST_BUSY] === 1'b0)
                return;
        end
        fails++;
        print_verdict();
    endtask
    task automatic op(input logic [2:0] c, input logic [19:0] a,
                      input logic [31:0] v);
        wr(fws_pkg::REG_ADDR, {12'h000, a});
        wr(fws_pkg::REG_DATA, v);
        wr(fws_pkg::REG_CMD, {29'h0000_0000, c});
        wait_idle();
        repeat (4) @(posedge mclk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // ==========================================================
    // scenarios
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
        repeat (6) @(posedge mclk);
        rd(fws_pkg::REG_STAT, 32'h0000_0080, 32'h0000_01FF);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            // bit 3 clear keeps the later erase-window read honest
            d = {24'h00_0000, seed[7:0] & 8'hE7};
            op(fws_pkg::OP_WRITE, seed[31:12], d);
            rd(fws_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0081);
            op(fws_pkg::OP_POLL, seed[31:12], d);
            rd(fws_pkg::REG_STAT, 32'h0000_0082, 32'h0000_00AE);
            rd(fws_pkg::REG_RES, d, 32'h0000_00FF);
            op(fws_pkg::OP_READ, seed[31:12] ^ 20'h0_0004, d);
            rd(fws_pkg::REG_RES, d, 32'h0000_00FF);
            wr(fws_pkg::REG_STAT, 32'h0000_0052);
        end
        op(fws_pkg::OP_ERASE_ADD, 20'h1_0000, 32'h0000_0030);
        rd(fws_pkg::REG_STAT, 32'h0000_0002, 32'h0000_0012);
        window_closed <= 1'b1;
        op(fws_pkg::OP_ERASE_ADD, 20'h2_0000, 32'h0000_0030);
        rd(fws_pkg::REG_STAT, 32'h0000_0012, 32'h0000_0012);
        window_closed <= 1'b0;
        op(fws_pkg::OP_POLL, 20'h1_0000, 32'h0000_0030);
        wr(fws_pkg::REG_STAT, 32'h0000_0052);
        suspend <= 1'b1;
        op(fws_pkg::OP_POLL, 20'h1_0000, 32'h0000_0030);
        rd(fws_pkg::REG_RES, 32'h0000_0080, 32'h0000_00E8);
        rd(fws_pkg::REG_STAT, 32'h0000_0080, 32'h0000_0080);
        suspend <= 1'b0;
        fail_mode <= 1'b1;
        op(fws_pkg::OP_WRITE, 20'h0_0100, 32'h0000_0055);
        op(fws_pkg::OP_POLL, 20'h0_0100, 32'h0000_0055);
        rd(fws_pkg::REG_STAT, 32'h0000_002C, 32'h0000_002C);
        op(fws_pkg::OP_READ, 20'h0_0100, 32'h0000_0000);
        rd(fws_pkg::REG_STAT, 32'h0000_0040, 32'h0000_0040);
        fail_mode <= 1'b0;
        op(fws_pkg::OP_WRITE, 20'h0_0000, 32'h0000_00F0);
        rd(fws_pkg::REG_STAT, 32'h0000_0080, 32'h0000_00A4);
        wr(fws_pkg::REG_STAT, 32'h0000_0052);
        op(fws_pkg::OP_UNPROTECT, 20'h0_0000, 32'h0000_0000);
        rd(fws_pkg::REG_STAT, 32'h0000_0040, 32'h0000_0040);
        wr(fws_pkg::REG_STAT, 32'h0000_0052);
        op(fws_pkg::OP_PROTECT, 20'h0_0000, 32'h0000_0000);
        wr(fws_pkg::REG_CFG, 32'h0000_0001);
        rd(fws_pkg::REG_CFG, 32'h0000_0001, 32'h0000_0001);
        // frozen clock enable must drop this write
        clk_en <= 1'b0;
        wr(fws_pkg::REG_CFG, 32'h0000_0000);
        clk_en <= 1'b1;
        rd(fws_pkg::REG_CFG, 32'h0000_0001, 32'h0000_0001);
        wr(fws_pkg::REG_CFG, 32'h0000_0000);
        op(fws_pkg::OP_VERIFY, 20'h0_0000, 32'h0000_0000);
        rd(fws_pkg::REG_STAT, 32'h0000_0100, 32'h0000_0100);
        op(fws_pkg::OP_UNPROTECT, 20'h0_0000, 32'h0000_0000);
        op(fws_pkg::OP_VERIFY, 20'h0_0000, 32'h0000_0000);
        rd(fws_pkg::REG_STAT, 32'h0000_0000, 32'h0000_0100);
        print_verdict();
    end
endmodule
